// ---- rtl/udma_pkg.sv ----
// shared timing constants and mode table for the data-in burst link
package udma_pkg;

    // ************************************************************
    // clock and timer widths
    // ************************************************************
    localparam int CLK_NS  = 20;
    localparam int TMR_W   = 8;
    localparam int DATA_W  = 16;
    localparam int MODES   = 5;

    // ************************************************************
    // interval figures in ns (plain defaults)
    // ************************************************************
    localparam int T_ACK_NS    = 20;
    localparam int T_ENV_NS    = 20;
    localparam int T_ZIORDY_NS = 20;
    localparam int T_ZAD_NS    = 20;
    localparam int T_DVS_NS    = 40;
    localparam int T_DVH_NS    = 80;
    localparam int T_RP_NS     = 160;
    localparam int T_MLI_NS    = 20;
    localparam int T_CYC0_NS   = 240;
    localparam int T_CYC1_NS   = 180;
    localparam int T_CYC2_NS   = 140;
    localparam int T_CYC3_NS   = 120;
    localparam int T_CYC4_NS   = 120;

    // least time rounded up, never under one cycle
    function automatic int cyc_up(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        cyc_up = (c < 1) ? 1 : c;
    endfunction

    localparam logic [TMR_W-1:0] T_ACK_CYC    = TMR_W'(cyc_up(T_ACK_NS));
    localparam logic [TMR_W-1:0] T_ENV_CYC    = TMR_W'(cyc_up(T_ENV_NS));
    localparam logic [TMR_W-1:0] T_ZIORDY_CYC = TMR_W'(cyc_up(T_ZIORDY_NS));
    localparam logic [TMR_W-1:0] T_ZAD_CYC    = TMR_W'(cyc_up(T_ZAD_NS));
    localparam logic [TMR_W-1:0] T_DVS_CYC    = TMR_W'(cyc_up(T_DVS_NS));
    localparam logic [TMR_W-1:0] T_DVH_CYC    = TMR_W'(cyc_up(T_DVH_NS));
    localparam logic [TMR_W-1:0] T_RP_CYC     = TMR_W'(cyc_up(T_RP_NS));
    localparam logic [TMR_W-1:0] T_MLI_CYC    = TMR_W'(cyc_up(T_MLI_NS));

    // ************************************************************
    // strobe spacing per mode
    // ************************************************************
    function automatic logic [TMR_W-1:0] cyc_for_mode(input logic [2:0] mode);
        case (mode)
            3'h0:    cyc_for_mode = TMR_W'(cyc_up(T_CYC0_NS));
            3'h1:    cyc_for_mode = TMR_W'(cyc_up(T_CYC1_NS));
            3'h2:    cyc_for_mode = TMR_W'(cyc_up(T_CYC2_NS));
            3'h3:    cyc_for_mode = TMR_W'(cyc_up(T_CYC3_NS));
            default: cyc_for_mode = TMR_W'(cyc_up(T_CYC4_NS));
        endcase
    endfunction

    localparam logic [2:0]  SYNC_RST = 3'h7;
    localparam logic [15:0] DD_PULL  = 16'hffff;

endpackage

// ---- rtl/udma_link_if.sv ----
// parallel link between device end and host end
`timescale 1ns/10ps
interface udma_link_if;
    logic        dmarq;
    logic        dmack_n;
    logic        stop;
    logic        hdmardy_n;
    logic        addr_quiet;
    logic        dstrobe_out;
    logic        dstrobe_oe;
    logic        dstrobe;
    logic [15:0] dd_dev_out;
    logic        dd_dev_oe;
    logic [15:0] dd_host_out;
    logic        dd_host_oe;
    logic [15:0] dd;

    // ************************************************************
    // bus resolution with pull-ups
    // ************************************************************
    assign dd      = dd_dev_oe ? dd_dev_out : (dd_host_oe ? dd_host_out : udma_pkg::DD_PULL);
    assign dstrobe = dstrobe_oe ? dstrobe_out : 1'b1;

    modport device (
        output dmarq,
        output dstrobe_out,
        output dstrobe_oe,
        output dd_dev_out,
        output dd_dev_oe,
        input  dmack_n,
        input  stop,
        input  hdmardy_n,
        input  dd
    );

    modport host (
        output dmack_n,
        output stop,
        output hdmardy_n,
        output addr_quiet,
        output dd_host_out,
        output dd_host_oe,
        input  dmarq,
        input  dstrobe,
        input  dd
    );
endinterface

// ---- rtl/udma_dev_end.sv ----
// device end of the data-in burst: request, strobe and word drive
`timescale 1ns/10ps

// Functional notes
// (RULE_01) host keeps acknowledge negated before burst
// (RULE_02) request held until first strobe fall
// (RULE_03) host asserts stop, drops ready, quiets selects
// (RULE_04) host keeps selects quiet through burst
// (RULE_05) host acknowledges tACK later, holds it
// (RULE_06) host frees data bus within tAZ
// (RULE_07) strobe driven tZIORDY after acknowledge, kept
// (RULE_08) host releases stop, asserts ready within tENV
// (RULE_09) data drive waits tZAD after host ready
// (RULE_10) first word placed on first drive
// (RULE_11) first strobe fall tDVS after word
// (RULE_12) each word then one strobe edge
// (RULE_13) strobe edges spaced by mode cycle time
// (RULE_14) data held tDVH after each edge
// (RULE_15) repeat until done or paused
// (RULE_16) no device pause before first word
// (RULE_17) pause stops edges, resume adds edge
// (RULE_18) host drops ready, waits tRP before stop
// (RULE_19) no host pause before first word
// (RULE_20) host pauses and resumes with ready
// (RULE_21) edges cease within tRFS of ready drop
// (RULE_22) slow modes host takes two extra words
// (RULE_23) fast modes host takes three extra
// (RULE_24) intervals are mode-selected cycle counts; only strobe spacing follows MODE here, the other intervals are fixed counts
module udma_dev_end #(
    parameter int DW = udma_pkg::DATA_W
) (
    input  wire logic          CORE_CLK,
    input  wire logic          SYS_RST,
    input  wire logic [2:0]    MODE,
    input  wire logic [DW-1:0] IN_DATA,
    input  wire logic          IN_VALID,
    output logic               IN_READY,
    input  wire logic          PAUSE_REQ,
    output logic               BURST_ACTIVE,
    udma_link_if.device        LINK
);

    initial
    begin
        if (DW != udma_pkg::DATA_W)
        begin
            $error("data width must match the link");
        end
    end

    typedef enum logic [5:0] {
        D_IDLE  = 6'h01,
        D_REQ   = 6'h02,
        D_ZIO   = 6'h04,
        D_ZAD   = 6'h08,
        D_XFER  = 6'h10,
        D_END   = 6'h20
    } dev_state_e;

    localparam logic [udma_pkg::TMR_W-1:0] GAP_MAX = '1;

    dev_state_e                   state;
    logic [2:0]                   sync1;
    logic [2:0]                   sync2;
    logic                         ack_on;
    logic                         stop_on;
    logic                         rdy_on;
    logic [udma_pkg::TMR_W-1:0]   tmr;
    logic [udma_pkg::TMR_W-1:0]   gap;
    logic [udma_pkg::TMR_W-1:0]   dvs;
    logic [udma_pkg::TMR_W-1:0]   cyc;
    logic [DW-1:0]                mem [2];
    logic                         wr_ptr;
    logic                         rd_ptr;
    logic [1:0]                   count;
    logic                         push;
    logic                         have_word;
    logic                         first_done;
    logic                         load;
    logic                         edge_go;
    logic                         dmarq;
    logic                         dstrobe_out;
    logic                         dstrobe_oe;
    logic [DW-1:0]                dd_out;
    logic                         dd_oe;

    // ************************************************************
    // link input synchronisers
    // ************************************************************
    always_ff @(posedge CORE_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            sync1 <= udma_pkg::SYNC_RST;
            sync2 <= udma_pkg::SYNC_RST;
        end
        else
        begin
            sync1 <= {LINK.dmack_n, LINK.stop, LINK.hdmardy_n};
            sync2 <= sync1;
        end
    end

    assign ack_on  = !sync2[2];
    assign stop_on = sync2[1];
    assign rdy_on  = !sync2[0];
    assign cyc     = udma_pkg::cyc_for_mode(MODE); // [RULE_24]

    // ************************************************************
    // two-entry word buffer
    // ************************************************************
    assign IN_READY = (count != 2'h2);
    assign push     = IN_VALID && IN_READY;

    always_ff @(posedge CORE_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= !wr_ptr;
            end
            if (edge_go)
            begin
                rd_ptr <= !rd_ptr;
            end
            count <= 2'(count + {1'b0, push} - {1'b0, edge_go});
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (push)
        begin
            mem[wr_ptr] <= IN_DATA;
        end
    end

    // ************************************************************
    // word load and strobe edge decisions
    // ************************************************************
    assign load = (state == D_XFER) && !have_word && (count != 2'h0) && !stop_on
                  && (gap >= udma_pkg::T_DVH_CYC); // [RULE_14] [RULE_10]
    assign edge_go = (state == D_XFER) && have_word && !stop_on
                     && (dvs >= udma_pkg::T_DVS_CYC) // [RULE_11] [RULE_12]
                     && (gap >= cyc) // [RULE_13]
                     && rdy_on // [RULE_21]
                     && !(PAUSE_REQ && first_done); // [RULE_16] [RULE_17]

    // ************************************************************
    // state sequence
    // ************************************************************
    always_ff @(posedge CORE_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            state <= D_IDLE;
            tmr   <= '0;
        end
        else
        begin
            case (state)
                D_IDLE:
                begin
                    tmr <= '0;
                    if (count != 2'h0 && !ack_on)
                    begin
                        state <= D_REQ;
                    end
                end
                D_REQ:
                begin
                    if (ack_on)
                    begin
                        state <= D_ZIO;
                    end
                end
                D_ZIO:
                begin
                    if (tmr >= udma_pkg::T_ZIORDY_CYC) // [RULE_07]
                    begin
                        tmr <= '0;
                        state <= D_ZAD;
                    end
                    else
                    begin
                        tmr <= tmr + 1'b1;
                    end
                end
                D_ZAD:
                begin
                    if (stop_on || !rdy_on)
                    begin
                        tmr <= '0;
                    end
                    else if (tmr >= udma_pkg::T_ZAD_CYC) // [RULE_09]
                    begin
                        state <= D_XFER;
                    end
                    else
                    begin
                        tmr <= tmr + 1'b1;
                    end
                end
                D_XFER:
                begin
                    if (stop_on && first_done)
                    begin
                        state <= D_END;
                    end
                end
                D_END:
                begin
                    if (!ack_on)
                    begin
                        state <= D_IDLE;
                    end
                end
                default:
                begin
                    state <= D_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // strobe spacing and data setup counters
    // ************************************************************
    always_ff @(posedge CORE_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            gap <= GAP_MAX;
            dvs <= '0;
        end
        else
        begin
            if (edge_go || state != D_XFER && state != D_END)
            begin
                gap <= edge_go ? '0 : GAP_MAX;
            end
            else if (gap != GAP_MAX)
            begin
                gap <= gap + 1'b1;
            end
            if (load)
            begin
                dvs <= '0;
            end
            else if (dvs != GAP_MAX)
            begin
                dvs <= dvs + 1'b1;
            end
        end
    end

    // ************************************************************
    // link outputs
    // ************************************************************
    always_ff @(posedge CORE_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            dmarq       <= 1'b0;
            dstrobe_out <= 1'b1;
            dstrobe_oe  <= 1'b0;
            dd_out      <= '0;
            dd_oe       <= 1'b0;
            have_word   <= 1'b0;
            first_done  <= 1'b0;
        end
        else
        begin
            dmarq <= (state == D_REQ) || (state == D_ZIO) || (state == D_ZAD)
                     || (state == D_XFER && !(stop_on && first_done)); // [RULE_02]
            if (state == D_ZAD)
            begin
                dstrobe_oe <= 1'b1; // [RULE_07]
            end
            else if (state == D_IDLE || (state == D_END && !ack_on))
            begin
                dstrobe_oe <= 1'b0;
            end
            if (edge_go)
            begin
                dstrobe_out <= !dstrobe_out; // [RULE_12] [RULE_15]
            end
            else if (state == D_END || state == D_IDLE)
            begin
                dstrobe_out <= 1'b1;
            end
            if (load)
            begin
                dd_out <= mem[rd_ptr]; // [RULE_10]
                dd_oe  <= 1'b1;
            end
            else if (state != D_XFER)
            begin
                dd_oe <= 1'b0;
            end
            if (load)
            begin
                have_word <= 1'b1;
            end
            else if (edge_go || state != D_XFER)
            begin
                have_word <= 1'b0;
            end
            if (edge_go)
            begin
                first_done <= 1'b1;
            end
            else if (state == D_IDLE)
            begin
                first_done <= 1'b0;
            end
        end
    end

    assign LINK.dmarq       = dmarq;
    assign LINK.dstrobe_out = dstrobe_out;
    assign LINK.dstrobe_oe  = dstrobe_oe;
    assign LINK.dd_dev_out  = dd_out;
    assign LINK.dd_dev_oe   = dd_oe;
    assign BURST_ACTIVE     = (state != D_IDLE);

endmodule

// ---- rtl/udma_host_end.sv ----
// host end of the data-in burst: acknowledge, pacing and word capture
`timescale 1ns/10ps
module udma_host_end #(
    parameter int DEPTH = 4
) (
    input  wire logic                         CORE_CLK,
    input  wire logic                         SYS_RST,
    input  wire logic                         HOST_EN,
    input  wire logic                         TERM_REQ,
    output logic [udma_pkg::DATA_W-1:0]       OUT_DATA,
    output logic                              OUT_VALID,
    input  wire logic                         OUT_READY,
    output logic                              BURST_ACTIVE,
    udma_link_if.host                         LINK
);

    initial
    begin
        if (DEPTH < 4 || DEPTH > 8)
        begin
            $error("depth must hold one word plus three late words");
        end
    end

    typedef enum logic [6:0] {
        H_IDLE  = 7'h01,
        H_SETUP = 7'h02,
        H_ENV   = 7'h04,
        H_XFER  = 7'h08,
        H_RP    = 7'h10,
        H_MLI   = 7'h20,
        H_HOLD  = 7'h40
    } host_state_e;

    localparam int PW = $clog2(DEPTH);

    host_state_e                    state;
    logic [udma_pkg::TMR_W-1:0]     tmr;
    logic [2:0]                     s_rq;
    logic [2:0]                     s_st;
    logic [udma_pkg::DATA_W-1:0]    dd1;
    logic [udma_pkg::DATA_W-1:0]    dd2;
    logic                           strobe_edge;
    logic [udma_pkg::DATA_W-1:0]    mem [DEPTH];
    logic [PW-1:0]                  wr_ptr;
    logic [PW-1:0]                  rd_ptr;
    logic [PW:0]                    count;
    logic                           push;
    logic                           pop;
    logic                           word_seen;

    // ************************************************************
    // link input synchronisers and strobe edge detect
    // ************************************************************
    always_ff @(posedge CORE_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            s_rq <= '0;
            s_st <= '1;
            dd1  <= '0;
            dd2  <= '0;
        end
        else
        begin
            s_rq <= {s_rq[1:0], LINK.dmarq};
            s_st <= {s_st[1:0], LINK.dstrobe};
            dd1  <= LINK.dd;
            dd2  <= dd1;
        end
    end

    assign strobe_edge = (s_st[2] != s_st[1]) && (state == H_XFER || state == H_RP);

    // ************************************************************
    // receive buffer
    // ************************************************************
    assign push      = strobe_edge && (count != (PW+1)'(DEPTH));
    assign pop       = OUT_VALID && OUT_READY;
    assign OUT_VALID = (count != '0);
    assign OUT_DATA  = mem[rd_ptr];

    always_ff @(posedge CORE_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= (PW+1)'(count + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop});
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (push)
        begin
            mem[wr_ptr] <= dd2; // [RULE_22] [RULE_23]
        end
    end

    // ************************************************************
    // burst sequence
    // ************************************************************
    always_ff @(posedge CORE_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            state     <= H_IDLE;
            tmr       <= '0;
            word_seen <= 1'b0;
        end
        else
        begin
            tmr <= tmr + 1'b1;
            if (push)
            begin
                word_seen <= 1'b1;
            end
            case (state)
                H_IDLE:
                begin
                    tmr       <= '0;
                    word_seen <= 1'b0;
                    if (HOST_EN && s_rq[1])
                    begin
                        state <= H_SETUP; // [RULE_03]
                    end
                end
                H_SETUP:
                begin
                    if (tmr >= udma_pkg::T_ACK_CYC) // [RULE_05]
                    begin
                        tmr   <= '0;
                        state <= H_ENV;
                    end
                end
                H_ENV:
                begin
                    if (tmr + 1'b1 >= udma_pkg::T_ENV_CYC) // [RULE_08]
                    begin
                        state <= H_XFER;
                    end
                end
                H_XFER:
                begin
                    tmr <= '0;
                    if ((TERM_REQ || !s_rq[1]) && word_seen)
                    begin
                        state <= H_RP; // [RULE_18]
                    end
                end
                H_RP:
                begin
                    if (tmr >= udma_pkg::T_RP_CYC) // [RULE_18]
                    begin
                        tmr   <= '0;
                        state <= H_MLI;
                    end
                end
                H_MLI:
                begin
                    if (s_rq[1])
                    begin
                        tmr <= '0;
                    end
                    else if (tmr >= udma_pkg::T_MLI_CYC)
                    begin
                        tmr   <= '0;
                        state <= H_HOLD;
                    end
                end
                H_HOLD:
                begin
                    if (tmr >= udma_pkg::T_ACK_CYC)
                    begin
                        state <= H_IDLE;
                    end
                end
                default:
                begin
                    state <= H_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // link outputs
    // ************************************************************
    assign LINK.dmack_n    = !(state == H_ENV || state == H_XFER || state == H_RP
                               || state == H_MLI); // [RULE_01] [RULE_05]
    assign LINK.stop       = (state == H_SETUP || state == H_MLI || state == H_HOLD);
    assign LINK.hdmardy_n  = (state == H_SETUP || state == H_RP || state == H_MLI
                              || state == H_HOLD
                              || (state == H_XFER && word_seen && count != '0)); // [RULE_19] [RULE_20]
    assign LINK.addr_quiet = (state != H_IDLE); // [RULE_04]
    assign LINK.dd_host_oe = (state == H_IDLE); // [RULE_06]
    assign LINK.dd_host_out = '0;
    assign BURST_ACTIVE    = (state != H_IDLE);

endmodule

// ---- verification/udma_link_props.sv ----
// concurrent checks on the burst link wires
`timescale 1ns/10ps
module udma_link_props (
    input wire logic        CORE_CLK,
    input wire logic        SYS_RST,
    input wire logic        dmarq,
    input wire logic        dmack_n,
    input wire logic        stop,
    input wire logic        hdmardy_n,
    input wire logic        addr_quiet,
    input wire logic        dstrobe_oe,
    input wire logic        dstrobe,
    input wire logic [15:0] dd,
    input wire logic        dd_dev_oe,
    input wire logic        dd_host_oe
);
    logic [7:0] gap;
    logic       last;
    wire        edge_seen = (dstrobe != last) && !stop && !dmack_n;

    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);

    // ****************************************
    // cycles since last strobe change
    // ****************************************
    always_ff @(posedge CORE_CLK or posedge SYS_RST)
        if (SYS_RST)
        begin
            gap  <= 8'hff;
            last <= 1'b1;
        end
        else
        begin
            last <= dstrobe;
            gap  <= (dstrobe != last) ? 8'h00 : ((gap == 8'hff) ? gap : gap + 8'h01);
        end

    // ****************************************
    // assertions
    // ****************************************
    ack_idle_a: assert property ($rose(dmarq) |-> dmack_n)
        else $error("request rose while acknowledged");
    req_hold_a: assert property ($fell(dmarq) |-> stop)
        else $error("request dropped without stop");
    sel_quiet_a: assert property (!dmack_n |-> addr_quiet)
        else $error("selects active in burst");
    ack_setup_a: assert property ($fell(dmack_n) |-> $past(stop) && $past(hdmardy_n))
        else $error("acknowledge before setup");
    bus_free_a: assert property ($fell(dmack_n) |-> !dd_host_oe)
        else $error("host still drives data");
    env_go_a: assert property ($fell(dmack_n) |=> !stop && !hdmardy_n)
        else $error("stop or ready late");
    strobe_kept_a: assert property (dstrobe_oe && !dmack_n |=> dstrobe_oe)
        else $error("strobe released in burst");
    data_late_a: assert property ($rose(dd_dev_oe) |-> !dmack_n && !stop && !hdmardy_n)
        else $error("data driven too early");
    data_setup_a: assert property (edge_seen |-> $stable(dd) && $past(dd_dev_oe, 2))
        else $error("strobe edge too soon after data");
    edge_gap_a: assert property (edge_seen |-> gap >= 8'h05)
        else $error("strobe edges too close");
    data_hold_a: assert property (edge_seen |=> $stable(dd) [*3])
        else $error("data changed inside hold");
    pause_stop_a: assert property (hdmardy_n [*7] |-> !edge_seen)
        else $error("strobe edge during host pause");

    cover property ($fell(dmack_n));
    cover property (hdmardy_n && !dmack_n && !stop);
    cover property ($rose(dmack_n));
endmodule

// ---- verification/tb_top.sv ----
// bench for the data-in burst link
`timescale 1ns/10ps
module tb_top;
    logic        CORE_CLK = 1'b0;
    logic        SYS_RST  = 1'b1;
    logic [2:0]  mode     = 3'h0;
    logic [15:0] in_data  = 16'h0000;
    logic        in_valid = 1'b0, pause_req = 1'b0, host_en = 1'b0, term_req = 1'b0;
    logic        out_ready = 1'b0, in_ready, out_valid, dev_busy, host_busy, last_s = 1'b1;
    logic [15:0] out_data;
    int          n_fail = 0, n_compared = 0, n_in = 0, k;
    int          q[$], wq[$];

    udma_link_if link ();
    udma_dev_end udma_dev_end_inst (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .MODE(mode),
        .IN_DATA(in_data), .IN_VALID(in_valid), .IN_READY(in_ready), .PAUSE_REQ(pause_req),
        .BURST_ACTIVE(dev_busy), .LINK(link));
    udma_host_end udma_host_end_inst (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .HOST_EN(host_en),
        .TERM_REQ(term_req), .OUT_DATA(out_data), .OUT_VALID(out_valid), .OUT_READY(out_ready),
        .BURST_ACTIVE(host_busy), .LINK(link));
    udma_link_props udma_link_props_inst (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST),
        .dmarq(link.dmarq), .dmack_n(link.dmack_n), .stop(link.stop),
        .hdmardy_n(link.hdmardy_n), .addr_quiet(link.addr_quiet), .dstrobe_oe(link.dstrobe_oe),
        .dstrobe(link.dstrobe), .dd(link.dd), .dd_dev_oe(link.dd_dev_oe),
        .dd_host_oe(link.dd_host_oe));

    always #10 CORE_CLK = ~CORE_CLK;

    task automatic tally_and_finish;
        if (n_fail == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bound;
        if (k >= 4000)
        begin
            n_fail++;
            tally_and_finish();
        end
    endtask

    // ****************************************
    // reference queues: input order, wire order
    // ****************************************
    always @(posedge CORE_CLK)
    begin
        if (in_valid && in_ready)
        begin
            q.push_back(int'(in_data));
            wq.push_back(int'(in_data));
            n_in++;
        end
        if (!link.dmack_n && !link.stop && link.dstrobe !== last_s && wq.size() > 0)
            chk(link.dd, 16'(wq.pop_front()));
        last_s = link.dstrobe;
        if (out_valid === 1'b1 && out_ready && q.size() > 0)
            chk(out_data, 16'(q.pop_front()));
    end

    task automatic send(input int n, input int pct);
        int goal;
        int seen;
        goal = n_in + n;
        seen = -1;
        for (k = 0; k < 4000 && n_in < goal; k++)
        begin
            @(negedge CORE_CLK);
            if (n_in != seen)
                in_data = 16'($urandom);
            seen = n_in;
            in_valid = 1'b1;
            out_ready = ($urandom % 100) < pct;
            pause_req = ($urandom % 16) == 0;
        end
        bound();
        @(negedge CORE_CLK);
        in_valid = 1'b0;
    endtask

    initial
    begin
        void'($urandom(32'hc4de));
        repeat (16) @(posedge CORE_CLK);
        @(negedge CORE_CLK);
        SYS_RST = 1'b0;
        send(2, 0);
        in_valid = 1'b1;
        repeat (20) @(negedge CORE_CLK);
        chk(16'(in_ready), 16'h0000);
        chk(16'(link.dmack_n), 16'h0001);
        chk(16'(link.dmarq), 16'h0001);
        chk(16'(dev_busy), 16'h0001);
        in_valid = 1'b0;
        host_en = 1'b1;
        for (int m = 0; m < 5; m++)
        begin
            mode = 3'(m);
            send(4 + m * 4, 10 + m * 20);
            for (k = 0; k < 4000 && q.size() > 0; k++)
            begin
                @(negedge CORE_CLK);
                out_ready = $urandom % 2;
                pause_req = ($urandom % 8) == 0;
            end
            bound();
            term_req = 1'b1;
            repeat (4) @(negedge CORE_CLK);
            for (k = 0; k < 4000 && host_busy !== 1'b0; k++)
                @(negedge CORE_CLK);
            bound();
            term_req = 1'b0;
            chk(16'(link.dmack_n), 16'h0001);
        end
        tally_and_finish();
    end
endmodule
